/* File: core/rtcta_target.sv */
`default_nettype none
module rtcta_target
  import rtcta_pkg::*;
#(
  parameter int unsigned FILTER = GLITCH_SAMPLES
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic hour12_mode_in,
  input wire logic power_on_flag_in,
  rtcta_if.target bus,
  output logic [6:0] alarm_minute_out,
  output logic [5:0] alarm_hour_out,
  output logic [5:0] alarm_hour24_out,
  output logic alarm_pm_out,
  output logic access_busy_out
);
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] reg_read(input logic [3:0] ptr, input logic [6:0] mn,
                                          input logic [5:0] hr);
    unique case (ptr)
      REG_ALARM_MIN: reg_read = {1'b0, mn};
      REG_ALARM_HOUR: reg_read = {2'b00, hr};
      default: reg_read = 8'h00;
    endcase
  endfunction : reg_read

  function automatic logic [5:0] to_24h(input logic [5:0] hr, input logic mode12);
    logic [3:0] units;
    logic [1:0] tens;
    units = hr[3:0] + 4'h2;
    tens = {1'b0, hr[4]} + 2'h1;
    if (units > 4'h9)
    begin
      units = units - 4'ha;
      tens = tens + 2'h1;
    end
    if (!mode12)
      to_24h = hr;
    else if (hr[4:0] == HOUR_NOON_BCD[4:0])
      to_24h = hr[HOUR_PM_BIT] ? HOUR_NOON_BCD : 6'h00;
    else if (hr[HOUR_PM_BIT])
      to_24h = {tens, units};
    else
      to_24h = {1'b0, hr[4:0]};
  endfunction : to_24h

  ////////////////////////////////////////////////////////////////////////
  logic scl_f;
  logic sda_f;
  logic scl_d_reg;
  logic sda_d_reg;
  rtcta_tgt_st_t st_reg, st_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] sh_reg, sh_next;
  logic [1:0] idx_reg, idx_next;
  logic rd_reg, rd_next;
  logic ack_reg, ack_next;
  logic [3:0] ptr_reg, ptr_next;
  logic [6:0] min_reg, min_next;
  logic [5:0] hour_reg, hour_next;
  logic oe_reg, oe_next;

  rtcta_line_sync #(.STABLE(FILTER)) u_scl_sync (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .d_in(bus.scl),
    .q_out(scl_f)
  );
  rtcta_line_sync #(.STABLE(FILTER)) u_sda_sync (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .d_in(bus.sda),
    .q_out(sda_f)
  );

  // Both lines pass equal filter delay, so their relative order is kept
  wire scl_rise = scl_f & ~scl_d_reg;
  wire scl_fall = ~scl_f & scl_d_reg;
  wire start_det = scl_f & scl_d_reg & sda_d_reg & ~sda_f;
  wire stop_det = scl_f & scl_d_reg & ~sda_d_reg & sda_f;
  wire byte_done = bit_reg == 4'h8;
  wire addr_hit = sh_reg[7:1] == TARGET_ADDR;
  wire [7:0] rd_byte = reg_read(ptr_reg, min_reg, hour_reg);
  wire [1:0] idx_inc = (idx_reg == 2'h2) ? idx_reg : idx_reg + 2'h1;

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_next = st_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    idx_next = idx_reg;
    rd_next = rd_reg;
    ack_next = ack_reg;
    ptr_next = ptr_reg;
    min_next = min_reg;
    hour_next = hour_reg;
    oe_next = oe_reg;
    if (power_on_flag_in)
    begin
      min_next = ALARM_MIN_RESET;
      hour_next = ALARM_HOUR_RESET;
    end
    if (stop_det)
    begin
      st_next = T_IDLE;
      oe_next = 1'b0;
      ptr_next = PTR_RESET;
    end
    else if (start_det)
    begin
      // A repeated start lands here too and keeps the pointer
      st_next = T_RX;
      bit_next = 4'h0;
      idx_next = 2'h0;
      oe_next = 1'b0;
    end
    else
    begin
      unique case (st_reg)
        T_IDLE:
        begin
          oe_next = 1'b0;
        end
        T_RX:
        begin
          if (scl_rise && !byte_done)
          begin
            sh_next = {sh_reg[6:0], sda_f};
            bit_next = bit_reg + 4'h1;
          end
          else if (scl_fall && byte_done)
          begin
            bit_next = 4'h0;
            idx_next = idx_inc;
            oe_next = 1'b1;
            st_next = T_RX_ACK;
            if (idx_reg == 2'h0)
            begin
              rd_next = sh_reg[0];
              if (!addr_hit)
              begin
                oe_next = 1'b0;
                st_next = T_IDLE;
              end
            end
            else if (idx_reg == 2'h1)
              ptr_next = sh_reg[7:4];
            else
            begin
              if (ptr_reg == REG_ALARM_MIN)
                min_next = sh_reg[6:0];
              if (ptr_reg == REG_ALARM_HOUR)
                hour_next = sh_reg[5:0];
              ptr_next = ptr_reg + 4'h1;
            end
          end
        end
        T_RX_ACK, T_TX_ACK:
        begin
          if (scl_rise && st_reg == T_TX_ACK)
            ack_next = ~sda_f;
          if (scl_fall)
          begin
            oe_next = 1'b0;
            bit_next = 4'h0;
            st_next = T_RX;
            if (st_reg == T_TX_ACK && !ack_reg)
              st_next = T_IDLE;
            else if (rd_reg)
            begin
              sh_next = rd_byte;
              oe_next = ~rd_byte[7];
              st_next = T_TX;
            end
          end
        end
        T_TX:
        begin
          if (scl_fall)
          begin
            bit_next = bit_reg + 4'h1;
            sh_next = {sh_reg[6:0], 1'b0};
            oe_next = ~sh_reg[6];
            if (bit_reg == 4'h7)
            begin
              oe_next = 1'b0;
              ptr_next = ptr_reg + 4'h1;
              st_next = T_TX_ACK;
            end
          end
        end
        default:
        begin
          st_next = T_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_in)
  begin
    if (!nrst_in)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      st_reg <= T_IDLE;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      idx_reg <= 2'h0;
      rd_reg <= 1'b0;
      ack_reg <= 1'b0;
      ptr_reg <= PTR_RESET;
      min_reg <= ALARM_MIN_RESET;
      hour_reg <= ALARM_HOUR_RESET;
      oe_reg <= 1'b0;
      alarm_hour24_out <= ALARM_HOUR_RESET;
      alarm_pm_out <= 1'b0;
      access_busy_out <= 1'b0;
    end
    else if (ce_in)
    begin
      scl_d_reg <= scl_f;
      sda_d_reg <= sda_f;
      st_reg <= st_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      idx_reg <= idx_next;
      rd_reg <= rd_next;
      ack_reg <= ack_next;
      ptr_reg <= ptr_next;
      min_reg <= min_next;
      hour_reg <= hour_next;
      oe_reg <= oe_next;
      alarm_hour24_out <= to_24h(hour_next, hour12_mode_in);
      alarm_pm_out <= hour12_mode_in & hour_next[HOUR_PM_BIT];
      access_busy_out <= st_next != T_IDLE;
    end
  end

  assign bus.sda_tgt_oe = oe_reg;
  assign alarm_minute_out = min_reg;
  assign alarm_hour_out = hour_reg;
endmodule : rtcta_target
`default_nettype wire

/* File: core/rtcta_pkg.sv */
`default_nettype none
package rtcta_pkg;
  // Target address and register map
  localparam logic [6:0] TARGET_ADDR = 7'h32;
  localparam logic [3:0] PTR_RESET = 4'hf;
  localparam logic [3:0] REG_ALARM_MIN = 4'hb;
  localparam logic [3:0] REG_ALARM_HOUR = 4'hc;
  localparam logic [3:0] FMT_WRITE = 4'h0;
  localparam logic [6:0] ALARM_MIN_RESET = 7'h00;
  localparam logic [5:0] ALARM_HOUR_RESET = 6'h00;
  localparam logic [5:0] HOUR_NOON_BCD = 6'h12;
  localparam int unsigned HOUR_PM_BIT = 5;
  // Line filter: samples a level must hold before it is believed
  localparam int unsigned GLITCH_SAMPLES = 2;
  // Host timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SCL_PERIOD_NS = 10000;
  localparam int unsigned SCL_QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  // Host registers, byte addresses on the Avalon-MM port
  localparam logic [3:0] CSR_CMD = 4'h0;
  localparam logic [3:0] CSR_STATUS = 4'h4;
  localparam int unsigned CMD_START_BIT = 0;
  localparam int unsigned CMD_STOP_BIT = 1;
  localparam int unsigned CMD_READ_BIT = 2;
  localparam int unsigned CMD_ACK_BIT = 3;
  localparam int unsigned CMD_TX_LSB = 8;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_ACK_BIT = 1;
  localparam int unsigned STAT_RX_LSB = 8;
  typedef enum logic [2:0] {T_IDLE, T_RX, T_RX_ACK, T_TX, T_TX_ACK} rtcta_tgt_st_t;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} rtcta_hst_st_t;
endpackage : rtcta_pkg
`default_nettype wire

/* File: core/rtcta_if.sv */
`default_nettype none
interface rtcta_if;
  logic scl_host_oe;
  logic sda_host_oe;
  logic sda_tgt_oe;
  logic scl;
  logic sda;
  // Open-drain wired-AND with pull-ups: any enable pulls the line low
  assign scl = ~scl_host_oe;
  assign sda = ~(sda_host_oe | sda_tgt_oe);
  modport target (input scl, input sda, output sda_tgt_oe);
  modport host (input sda, output scl_host_oe, output sda_host_oe);
endinterface : rtcta_if
`default_nettype wire

/* File: core/rtcta_line_sync.sv */
`default_nettype none
module rtcta_line_sync #(
  parameter int unsigned STABLE = 2
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic d_in,
  output logic q_out
);
  logic meta_reg;
  logic sync_reg;
  logic [3:0] cnt_reg;
  wire differs = sync_reg != q_out;
  wire settled = cnt_reg == 4'(STABLE - 1);
  // Idle bus level is high, so the filter wakes up high
  always_ff @(posedge clk_sys_in)
  begin
    if (!nrst_in)
    begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      q_out <= 1'b1;
      cnt_reg <= 4'h0;
    end
    else if (ce_in)
    begin
      meta_reg <= d_in;
      sync_reg <= meta_reg;
      cnt_reg <= (differs && !settled) ? cnt_reg + 4'h1 : 4'h0;
      if (differs && settled)
        q_out <= sync_reg;
    end
  end
endmodule : rtcta_line_sync
`default_nettype wire

/* File: core/rtcta_master.sv */
`default_nettype none
module rtcta_master
  import rtcta_pkg::*;
#(
  parameter int unsigned QUARTER = SCL_QUARTER_CYC
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  rtcta_if.host bus
);
  rtcta_hst_st_t st_reg;
  logic [15:0] q_cnt_reg;
  logic [1:0] phase_reg;
  logic [3:0] bit_reg;
  logic stop_reg;
  logic read_reg;
  logic ack_tx_reg;
  logic ack_rx_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic scl_oe_reg;
  logic sda_oe_reg;
  logic sda_f;

  rtcta_line_sync #(.STABLE(GLITCH_SAMPLES)) u_sda_sync (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .d_in(bus.sda),
    .q_out(sda_f)
  );

  ////////////////////////////////////////////////////////////////////////
  wire busy = st_reg != H_IDLE;
  wire req_new = (avs_read_in | avs_write_in) & avs_waitrequest_out;
  wire cmd_take = avs_write_in & ~avs_waitrequest_out & (avs_address_in == CSR_CMD) & ~busy;
  wire tick = busy && (q_cnt_reg == 16'(QUARTER - 1));
  wire ack_bit = bit_reg == 4'h8;
  wire [31:0] status = {16'h0000, rx_reg, 6'h00, ack_rx_reg, busy};
  wire [31:0] rd_mux = (avs_address_in == CSR_STATUS) ? status : 32'h0000_0000;
  // Data bit for phase 0: a reader releases data bits and drives only its acknowledge
  wire sda_bit_oe = ack_bit ? (read_reg & ack_tx_reg) : (~read_reg & ~tx_reg[7]);

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_in)
  begin
    if (!nrst_in)
    begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h0000_0000;
    end
    else if (ce_in)
    begin
      avs_waitrequest_out <= ~req_new;
      if (req_new)
        avs_readdata_out <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // A command byte without start must follow one that left SCL low
  always_ff @(posedge clk_sys_in)
  begin
    if (!nrst_in)
    begin
      st_reg <= H_IDLE;
      q_cnt_reg <= 16'h0000;
      phase_reg <= 2'h0;
      bit_reg <= 4'h0;
      stop_reg <= 1'b0;
      read_reg <= 1'b0;
      ack_tx_reg <= 1'b0;
      ack_rx_reg <= 1'b0;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      q_cnt_reg <= (tick || !busy) ? 16'h0000 : q_cnt_reg + 16'h0001;
      if (cmd_take)
      begin
        st_reg <= avs_writedata_in[CMD_START_BIT] ? H_START : H_BIT;
        stop_reg <= avs_writedata_in[CMD_STOP_BIT];
        read_reg <= avs_writedata_in[CMD_READ_BIT];
        ack_tx_reg <= avs_writedata_in[CMD_ACK_BIT];
        tx_reg <= avs_writedata_in[CMD_TX_LSB +: 8];
        phase_reg <= 2'h0;
        bit_reg <= 4'h0;
      end
      else if (tick)
      begin
        phase_reg <= phase_reg + 2'h1;
        unique case (st_reg)
          H_START:
          begin
            unique case (phase_reg)
              2'h0: sda_oe_reg <= 1'b0;
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: sda_oe_reg <= 1'b1;
              2'h3:
              begin
                scl_oe_reg <= 1'b1;
                st_reg <= H_BIT;
              end
            endcase
          end
          H_BIT:
          begin
            unique case (phase_reg)
              2'h0: sda_oe_reg <= sda_bit_oe;
              2'h1: scl_oe_reg <= 1'b0;
              2'h2:
              begin
                if (ack_bit)
                  ack_rx_reg <= ~sda_f;
                else
                  rx_reg <= {rx_reg[6:0], sda_f};
              end
              2'h3:
              begin
                scl_oe_reg <= 1'b1;
                tx_reg <= {tx_reg[6:0], 1'b0};
                bit_reg <= bit_reg + 4'h1;
                if (ack_bit)
                begin
                  sda_oe_reg <= 1'b0;
                  st_reg <= stop_reg ? H_STOP : H_IDLE;
                end
              end
            endcase
          end
          H_STOP:
          begin
            unique case (phase_reg)
              2'h0: sda_oe_reg <= 1'b1;
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: sda_oe_reg <= 1'b0;
              2'h3: st_reg <= H_IDLE;
            endcase
          end
          H_IDLE:
          begin
            st_reg <= H_IDLE;
          end
        endcase
      end
    end
  end

  assign bus.scl_host_oe = scl_oe_reg;
  assign bus.sda_host_oe = sda_oe_reg;
endmodule : rtcta_master
`default_nettype wire

/* File: test/rtcta_properties.sv */
`default_nettype none
module rtcta_properties
  import rtcta_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic scl_host_oe,
  input wire logic sda_host_oe,
  input wire logic sda_tgt_oe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_q_reg;
  logic sda_q_reg;
  logic rd_reg;
  logic hit_reg;
  logic data_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg;
  // Watches the raw lines, so it runs ahead of the target's filtered view
  wire start_w = scl && scl_q_reg && sda_q_reg && !sda;
  wire stop_w = scl && scl_q_reg && !sda_q_reg && sda;
  wire rise_w = scl && !scl_q_reg;
  wire fall_w = !scl && scl_q_reg;
  wire ninth_w = rise_w && cnt_reg == 4'h8;
  always_ff @(posedge clk_sys_in)
  begin
    scl_q_reg <= scl || !nrst_in;
    sda_q_reg <= sda || !nrst_in;
    if (start_w || !nrst_in)
    begin
      cnt_reg <= 4'h0;
      data_reg <= 1'b0;
    end
    else if (rise_w && cnt_reg < 4'h8)
    begin
      cnt_reg <= cnt_reg + 4'h1;
      sh_reg <= {sh_reg[6:0], sda};
    end
    else if (ninth_w)
      cnt_reg <= 4'h9;
    else if (fall_w && cnt_reg == 4'h9)
    begin
      cnt_reg <= 4'h0;
      data_reg <= 1'b1;
    end
    if (ninth_w && !data_reg)
    begin
      hit_reg <= sh_reg[7:1] == TARGET_ADDR;
      rd_reg <= sh_reg[0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);
  property p_idle_reset;
    $rose(nrst_in) |-> scl && sda && !scl_host_oe && !sda_host_oe && !sda_tgt_oe;
  endproperty
  a_idle_reset: assert property (p_idle_reset) else $error("bus not idle after reset");
  property p_open_drain;
    $rose(sda_tgt_oe) |-> !scl;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("target began pulling with clock high");
  property p_tgt_steady;
    scl && $past(scl) |-> $stable(sda_tgt_oe);
  endproperty
  a_tgt_steady: assert property (p_tgt_steady) else $error("target changed data with clock high");
  property p_addr_ack;
    ninth_w && !data_reg |-> sda == (sh_reg[7:1] != TARGET_ADDR);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address acknowledge wrong");
  property p_wr_ack;
    ninth_w && data_reg && hit_reg && !rd_reg |-> !sda;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("written byte not acknowledged");
  property p_tx_release;
    ninth_w && data_reg && hit_reg && rd_reg |-> !sda_tgt_oe;
  endproperty
  a_tx_release: assert property (p_tx_release) else $error("transmitter held line at ninth clock");
  property p_ack_release;
    fall_w && cnt_reg == 4'h9 && hit_reg && !rd_reg |-> ##[1:8] !sda_tgt_oe;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("acknowledge not released");
  property p_nack_release;
    ninth_w && data_reg && hit_reg && rd_reg && sda |-> ##16 !sda_tgt_oe [*8];
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("line driven after missing ack");
  property p_stop_quiet;
    stop_w |-> !sda_tgt_oe ##1 !sda_tgt_oe [*8];
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("target drives after stop");
  c_start: cover property (start_w);
  c_stop: cover property (stop_w);
  c_nack: cover property (ninth_w && data_reg && rd_reg && sda);
  c_foreign: cover property (ninth_w && !data_reg && sda);
endmodule : rtcta_properties
`default_nettype wire

/* File: test/rtc_two_wire_target_and_daily_alarm_test.sv */
`default_nettype none
module rtc_two_wire_target_and_daily_alarm_test
  import rtcta_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] AW = {TARGET_ADDR, 1'b0};
  localparam logic [7:0] AR = {TARGET_ADDR, 1'b1};
  typedef struct packed {logic [3:0] ptr; logic [7:0] wd; logic h12; logic [7:0] rb; logic [5:0] h24; logic pm;}
    rtcta_row_t;
  rtcta_row_t rows [6] = '{
    '{4'hb, 8'hd9, 1'b0, 8'h59, 6'h00, 1'b0},
    '{4'hc, 8'hd2, 1'b1, 8'h12, 6'h00, 1'b0},
    '{4'hc, 8'h32, 1'b1, 8'h32, 6'h12, 1'b1},
    '{4'hc, 8'h21, 1'b1, 8'h21, 6'h13, 1'b1},
    '{4'hc, 8'h23, 1'b0, 8'h23, 6'h23, 1'b0},
    '{4'ha, 8'h55, 1'b0, 8'h00, 6'h23, 1'b0}};
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic h12 = 1'b0;
  logic power_on_flag = 1'b0;
  logic ce = 1'b1;
  logic a_busy;
  logic [3:0] av_addr = 4'h0;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wdata = 32'h0;
  logic [31:0] av_rdata;
  logic av_wait;
  logic [6:0] a_min;
  logic [5:0] a_hour;
  logic [5:0] a_h24;
  logic a_pm;
  int fails = 0;
  int checked = 0;
  rtcta_if bus_if();
  rtcta_target rtcta_target_inst (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .ce_in(ce), .hour12_mode_in(h12),
    .power_on_flag_in(power_on_flag), .bus(bus_if.target), .alarm_minute_out(a_min), .alarm_hour_out(a_hour),
    .alarm_hour24_out(a_h24), .alarm_pm_out(a_pm), .access_busy_out(a_busy));
  // Short clock phases keep the run brief but stay above the filter latency
  rtcta_master #(.QUARTER(8)) rtcta_master_inst (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .ce_in(ce),
    .avs_address_in(av_addr), .avs_read_in(av_rd), .avs_write_in(av_wr), .avs_writedata_in(av_wdata),
    .avs_readdata_out(av_rdata), .avs_waitrequest_out(av_wait), .bus(bus_if.host));
  rtcta_properties rtcta_properties_inst (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .scl_host_oe(bus_if.scl_host_oe), .sda_host_oe(bus_if.sda_host_oe), .sda_tgt_oe(bus_if.sda_tgt_oe),
    .scl(bus_if.scl), .sda(bus_if.sda));
  always #5 clk_sys_in = ~clk_sys_in;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic bus_op(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    av_addr <= a;
    av_wdata <= d;
    av_wr <= wr;
    av_rd <= !wr;
    do
      @(posedge clk_sys_in);
    while (av_wait !== 1'b0);
    q = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    @(posedge clk_sys_in);
  endtask : bus_op
  task automatic xfer(input logic [3:0] f, input logic [7:0] tx, output logic [7:0] rx, output logic ak);
    logic [31:0] s;
    bus_op(1'b1, CSR_CMD, {16'h0, tx, 4'h0, f}, s);
    do
      bus_op(1'b0, CSR_STATUS, 32'h0, s);
    while (s[STAT_BUSY_BIT] !== 1'b0);
    rx = s[STAT_RX_LSB +: 8];
    ak = s[STAT_ACK_BIT];
  endtask : xfer
  task automatic put(input logic [3:0] f, input logic [7:0] tx, input logic exp_ak);
    logic [7:0] rx;
    logic ak;
    xfer(f, tx, rx, ak);
    check("ack", {31'h0, ak}, {31'h0, exp_ak});
  endtask : put
  task automatic get(input logic last, input logic [7:0] exp);
    logic [7:0] rx;
    logic ak;
    xfer(last ? 4'h6 : 4'hc, 8'hff, rx, ak);
    check("rx", {24'h0, rx}, {24'h0, exp});
  endtask : get
  task automatic summarize();
    $display("counts: checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #600000;
    fails++;
    summarize();
  end
  initial
  begin
    repeat (4) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    check("idle", {30'h0, bus_if.scl, bus_if.sda}, 32'h3);
    check("minute", {25'h0, a_min}, 32'h0);
    $display("test reset done");
    foreach (rows[i])
    begin
      h12 <= rows[i].h12;
      put(4'h1, AW, 1'b1);
      put(4'h0, {rows[i].ptr, FMT_WRITE}, 1'b1);
      check("busy", {31'h0, a_busy}, 32'h1);
      put(4'h2, rows[i].wd, 1'b1);
      put(4'h1, AW, 1'b1);
      put(4'h0, {rows[i].ptr, FMT_WRITE}, 1'b1);
      put(4'h1, AR, 1'b1);
      get(1'b1, rows[i].rb);
      check("hour24", {26'h0, a_h24}, {26'h0, rows[i].h24});
      check("pm", {31'h0, a_pm}, {31'h0, rows[i].pm});
      check("idle busy", {31'h0, a_busy}, 32'h0);
      $display("test row %0d done", i);
    end
    put(4'h1, {7'h33, 1'b0}, 1'b0);
    put(4'h2, 8'h00, 1'b0);
    put(4'h1, {7'h72, 1'b1}, 1'b0);
    put(4'h2, 8'h00, 1'b0);
    $display("test foreign address done");
    put(4'h1, AW, 1'b1);
    put(4'h0, {REG_ALARM_MIN, FMT_WRITE}, 1'b1);
    put(4'h0, 8'h45, 1'b1);
    put(4'h2, 8'h07, 1'b1);
    put(4'h1, AR, 1'b1);
    for (int i = 0; i < 14; i++)
      get(i == 13, (i == 12) ? 8'h45 : (i == 13) ? 8'h07 : 8'h00);
    check("hour", {26'h0, a_hour}, 32'h7);
    $display("test wrap done");
    // Clock enable low must hold the alarm even while the clear is requested
    ce <= 1'b0;
    power_on_flag <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    check("frozen minute", {25'h0, a_min}, 32'h45);
    ce <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    power_on_flag <= 1'b0;
    @(posedge clk_sys_in);
    check("pon minute", {25'h0, a_min}, 32'h0);
    check("pon hour", {26'h0, a_hour}, 32'h0);
    $display("test power-on done");
    put(4'h1, AW, 1'b1);
    put(4'h0, {REG_ALARM_MIN, FMT_WRITE}, 1'b1);
    put(4'h2, 8'h45, 1'b1);
    check("written minute", {25'h0, a_min}, 32'h45);
    nrst_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    check("reset minute", {25'h0, a_min}, 32'h0);
    check("reset busy", {31'h0, a_busy}, 32'h0);
    check("reset idle", {30'h0, bus_if.scl, bus_if.sda}, 32'h3);
    $display("test mid-run reset done");
    summarize();
  end
endmodule : rtc_two_wire_target_and_daily_alarm_test
`default_nettype wire
